// [bench/concentrator_model.sv]
/* link receiver in place of the concentrator
   takes 3 lanes a clock, earliest bit on the top lane */
`timescale 1ns/100ps
module concentrator_model (
    input wire sys_clk_i,
    input wire rstn_i,
    input wire [2:0] tx_data_i,
    input wire tx_frame_i,
    output reg [89:0] frame_o,
    output reg done_o
);
    reg busy_q;
    // samples every frame cycle: a receiver that cannot stall the sender
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_o <= 90'h0;
            busy_q <= 1'b0;
            done_o <= 1'b0;
        end else if (tx_frame_i) begin
            frame_o <= {frame_o[86:0], tx_data_i};
            busy_q <= 1'b1;
            done_o <= 1'b0;
        end else begin
            done_o <= busy_q;
            busy_q <= 1'b0;
        end
    end
endmodule

// [bench/frontend_sva.sv]
/* port checker for the strip front end
   bound to the top module from the testbench */
`timescale 1ns/100ps
module frontend_sva #(
    parameter NUM_CHAN = 64,
    parameter LANES = 3
) (
    input wire sys_clk_i,
    input wire rstn_i,
    input wire [NUM_CHAN-1:0] hit_i,
    input wire ts_reset_i,
    input wire [7:0] threshold_i,
    input wire accept_mode_i,
    input wire ovf_clear_i,
    input wire [7:0] threshold_o,
    input wire [LANES-1:0] tx_data_o,
    input wire tx_frame_o,
    input wire overflow_o,
    input wire [23:0] timestamp_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    reg [5:0] len_q;
    always @(posedge sys_clk_i or negedge rstn_i)
        if (!rstn_i) len_q <= 6'h00;
        else len_q <= tx_frame_o ? len_q + 6'h01 : 6'h00;
    sequence new_hit;
        !accept_mode_i && |(hit_i & ~$past(hit_i));
    endsequence
    sequence frame_start;
        $rose(tx_frame_o);
    endsequence
    a_ts_clear: assert property (ts_reset_i |=> timestamp_o == 24'h0)
        else $error("stamp not cleared");
    a_ts_step: assert property (!$past(ts_reset_i) && $changed(timestamp_o)
        |-> timestamp_o == $past(timestamp_o) + 24'h1) else $error("stamp step");
    a_thr_copy: assert property ($past(rstn_i)
        |-> threshold_o == $past(threshold_i)) else $error("threshold copy");
    a_idle_zero: assert property (!tx_frame_o |-> tx_data_o == 3'h0)
        else $error("lanes busy when idle");
    a_frame_hdr: assert property (frame_start |-> tx_data_o[LANES-1 -: 2] == 2'h2)
        else $error("bad header");
    a_frame_len: assert property ($fell(tx_frame_o) |-> len_q == 6'h1E)
        else $error("frame length");
    a_frame_max: assert property (len_q <= 6'h1E)
        else $error("frame too long");
    a_ovf_hold: assert property (overflow_o && !ovf_clear_i |=> overflow_o)
        else $error("overflow lost");
    a_hit_sent: assert property (new_hit |-> ##[1:200] tx_frame_o)
        else $error("hit never sent");
endmodule

// [bench/testbench.sv]
/* self-checking bench for the strip front end
   needs the link model and the port checker */
`timescale 1ns/100ps
module testbench;
    reg clk, rstn, ts_rst, mode, ovf_clr;
    reg [63:0] hit;
    reg [7:0] thr;
    reg [6:0] min_hits;
    wire [7:0] thr_o;
    wire [2:0] lanes;
    wire frame, ovf, rx_done;
    wire [23:0] ts;
    wire [89:0] rx;
    reg [87:0] expq[$];
    integer seed = 32'h3465, failures = 0, total_checks = 0, cyc = 0, n = 0, i;
    strip_hit_timestamp_frontend strip_hit_timestamp_frontend_i (
        .sys_clk_i(clk), .rstn_i(rstn), .hit_i(hit), .ts_reset_i(ts_rst),
        .threshold_i(thr), .accept_mode_i(mode), .min_hits_i(min_hits),
        .ovf_clear_i(ovf_clr), .threshold_o(thr_o), .tx_data_o(lanes),
        .tx_frame_o(frame), .overflow_o(ovf), .timestamp_o(ts));
    concentrator_model concentrator_model_i (.sys_clk_i(clk), .rstn_i(rstn),
        .tx_data_i(lanes), .tx_frame_i(frame), .frame_o(rx), .done_o(rx_done));
    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task check(input string what, input [89:0] seen, input [89:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("ERROR %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // edges since the last counter reset, four per stamp count
    always @(posedge clk) begin
        n <= ts_rst ? 0 : n + 1;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    always @(posedge clk) if (rx_done) begin
        if (expq.size() == 0) check("spare event", 90'h1, 90'h0);
        else check("event", rx, {2'h2, expq.pop_front()});
    end
    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    task put(input [63:0] val, input keep);
        reg [23:0] t;
        begin
            @(posedge clk);
            val = val & ~hit;
            t = (n + 1) >> 2;
            hit <= val;
            thr <= $random(seed);
            if (keep && val != 0 && (!mode || $countones(val) >= min_hits))
                expq.push_back({t, val});
        end
    endtask
    task drain;
        begin
            i = 0;
            while ((expq.size() != 0 || frame) && i < 400) begin
                @(posedge clk);
                i = i + 1;
            end
            repeat (2) put(64'h0, 1'b0);
            check("queue empty", expq.size(), 90'h0);
        end
    endtask
    initial begin
        rstn = 0; hit = 0; ts_rst = 0; mode = 0;
        ovf_clr = 0; thr = 0; min_hits = 0;
        repeat (10) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        ts_rst <= 1;
        thr <= $random(seed);
        @(posedge clk);
        ts_rst <= 0;
        repeat (12) @(posedge clk);
        #1 check("stamp", ts, 90'h3);
        check("threshold", thr_o, thr);
        $display("test counter reset done");
        for (i = 0; i < 8; i = i + 1)
            put({$random(seed), $random(seed)}, i < 5);
        put(64'h0, 1'b0);
        drain;
        check("overflow", ovf, 90'h1);
        ovf_clr <= 1;
        @(posedge clk);
        ovf_clr <= 0;
        @(posedge clk);
        #1 check("overflow clear", ovf, 90'h0);
        $display("test overflow done");
        @(posedge clk);
        mode <= 1;
        for (i = 0; i < 4; i = i + 1) begin
            min_hits <= i < 2 ? 7'h03 : 7'h40;
            put(i == 0 ? 64'h3 : i == 1 ? 64'h7 : i == 2 ? ~64'h0 : ~64'h0 >> 1,
                1'b1);
            repeat (6) put(64'h0, 1'b0);
        end
        drain;
        $display("test multiplicity done");
        end_of_test;
    end
endmodule
bind strip_hit_timestamp_frontend frontend_sva #(.NUM_CHAN(NUM_CHAN),
    .LANES(LANES)) frontend_sva_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .hit_i(hit_i), .ts_reset_i(ts_reset_i), .threshold_i(threshold_i),
    .accept_mode_i(accept_mode_i), .ovf_clear_i(ovf_clear_i),
    .threshold_o(threshold_o), .tx_data_o(tx_data_o),
    .tx_frame_o(tx_frame_o), .overflow_o(overflow_o),
    .timestamp_o(timestamp_o));

// [inc/strip_hit_timestamp_frontend_defines.vh]
/*
 * Constants for the strip hit timestamp front end: clock rates, timestamp
 * sizing, event word layout, link framing and buffer sizes.
 * Assumes it is included by bare name from the design file.
 */
`ifndef STRIP_HIT_TIMESTAMP_FRONTEND_DEFINES_VH
`define STRIP_HIT_TIMESTAMP_FRONTEND_DEFINES_VH

// ----------------------------------------------------------------
// clocks and timestamp
// ----------------------------------------------------------------
`define SYS_CLK_HZ 40000000
`define TS_RESOLUTION_NS 100
`define TS_CLK_HZ 10000000
`define TS_RESET_HZ 1
`define TS_DIV (`SYS_CLK_HZ / `TS_CLK_HZ)
`define TS_SPAN (`TS_CLK_HZ / `TS_RESET_HZ)

// ----------------------------------------------------------------
// channels, event word, thresholds
// ----------------------------------------------------------------
`define NUM_CHAN 64
`define WORD_BITS 88
`define THR_W 8
`define MODE_AUTO 1'h0
`define PIPE_DEPTH 4
`define FIFO_DEPTH 4

// ----------------------------------------------------------------
// serial link
// ----------------------------------------------------------------
`define LINK_MHZ 100
`define LINK_LANES ((`LINK_MHZ * 1000000 + `SYS_CLK_HZ - 1) / `SYS_CLK_HZ)
`define HDR_BITS 2
`define HDR_CODE 2'h2
`define FRAME_BITS (`WORD_BITS + `HDR_BITS)
`define FRAME_CYCLES ((`FRAME_BITS + `LINK_LANES - 1) / `LINK_LANES)
`define EVENT_MAX_NS 1000
`define EVENT_MAX_CYCLES (`EVENT_MAX_NS * (`SYS_CLK_HZ / 1000000) / 1000)

`endif

// [rtl/strip_hit_timestamp_frontend.v]
/*
 * Digital logic of a 64-channel strip front end: hit sampling pipeline,
 * synchronised timestamp counter, acceptance, event queue and serial link.
 * Assumes discriminator bits, the counter reset and all controls are
 * synchronous to sys_clk_i; the concentrator samples every link cycle.
 */
// Functional notes
// - timestamp advances on common clock tick, clears on global counter reset.
// - on any hit, current timestamp is captured beside that hit pattern.
// - one timestamp count per 100 ns tick, 10 MHz made from system clock.
// - counter sized to span a full 1 Hz reset interval without wrapping.
// - 64 hit channels, one discriminator bit each per clock.
// - one common threshold setting drives all channels of the chip.
// - rising edges (0 to 1 changes) are sampled into a shift register every clock.
// - at shift register output each sample is written or discarded.
// - stored event is timestamp plus 64-bit hit pattern.
// - accept mode is auto nonzero or a minimum hit multiplicity.
// - transmitter sends while queue holds events, idles when empty.
// - queue holds several whole events in first-in first-out order.
// - link carries at least 100 Mbit/s; receiver samples every cycle.
// - each output word is 88 bits for one clock period's state.
// - one framed event leaves within 1 us.
`timescale 1ns/100ps
`include "strip_hit_timestamp_frontend_defines.vh"

module strip_hit_timestamp_frontend #(
    parameter NUM_CHAN = `NUM_CHAN,
    parameter PIPE_DEPTH = `PIPE_DEPTH,
    parameter FIFO_DEPTH = `FIFO_DEPTH,
    parameter LANES = `LINK_LANES
) (
    input wire sys_clk_i,
    input wire rstn_i,
    input wire [NUM_CHAN-1:0] hit_i,
    input wire ts_reset_i,
    input wire [`THR_W-1:0] threshold_i,
    input wire accept_mode_i,
    input wire [6:0] min_hits_i,
    input wire ovf_clear_i,
    output wire [`THR_W-1:0] threshold_o,
    output wire [LANES-1:0] tx_data_o,
    output wire tx_frame_o,
    output wire overflow_o,
    output wire [23:0] timestamp_o
);

// ----------------------------------------------------------------
// local sizes
// ----------------------------------------------------------------
localparam TS_W = $clog2(`TS_SPAN);
localparam DIV_W = $clog2(`TS_DIV);
localparam integer DIV_END = `TS_DIV - 1;
localparam [DIV_W-1:0] DIV_LAST = DIV_END[DIV_W-1:0];
localparam [TS_W-1:0] TS_MAX = {TS_W{1'b1}};
localparam AW = $clog2(FIFO_DEPTH);
localparam integer DEPTH_END = FIFO_DEPTH;
localparam integer PTR_END = FIFO_DEPTH - 1;
localparam [AW:0] FIFO_FULL = DEPTH_END[AW:0];
localparam [AW-1:0] PTR_LAST = PTR_END[AW-1:0];
localparam FB = LANES * `FRAME_CYCLES;
localparam CW = $clog2(`FRAME_CYCLES + 1);
localparam integer FRAME_END = `FRAME_CYCLES - 1;
localparam [CW-1:0] FRAME_LAST = FRAME_END[CW-1:0];
localparam S_IDLE = 2'h1;
localparam S_SEND = 2'h2;

function [6:0] popcount;
    input [NUM_CHAN-1:0] v;
    integer k;
    begin
        popcount = 7'h00;
        for (k = 0; k < NUM_CHAN; k = k + 1) begin
            popcount = popcount + {6'h00, v[k]};
        end
    end
endfunction

// ----------------------------------------------------------------
// threshold and timestamp counter
// ----------------------------------------------------------------
reg [`THR_W-1:0] thr_q;
reg [DIV_W-1:0] div_q;
reg [TS_W-1:0] ts_q;
wire tick = (div_q == DIV_LAST);

always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        thr_q <= {`THR_W{1'b0}};
        div_q <= {DIV_W{1'b0}};
        ts_q <= {TS_W{1'b0}};
    end else begin
        thr_q <= threshold_i;
        if (ts_reset_i) begin
            // divider realigned too, so every chip ticks in phase
            div_q <= {DIV_W{1'b0}};
            ts_q <= {TS_W{1'b0}};
        end else begin
            div_q <= tick ? {DIV_W{1'b0}} : div_q + 1'b1;
            // saturate rather than wrap if a reset is ever missed
            if (tick && ts_q != TS_MAX) begin
                ts_q <= ts_q + 1'b1;
            end
        end
    end
end

assign threshold_o = thr_q;
assign timestamp_o = ts_q;

// ----------------------------------------------------------------
// hit sampling shift register
// ----------------------------------------------------------------
reg [NUM_CHAN-1:0] prev_q;
reg [NUM_CHAN-1:0] sr_hit_q [0:PIPE_DEPTH-1];
reg [TS_W-1:0] sr_ts_q [0:PIPE_DEPTH-1];
wire [NUM_CHAN-1:0] edges = hit_i & ~prev_q;

always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        prev_q <= {NUM_CHAN{1'b0}};
        sr_hit_q[0] <= {NUM_CHAN{1'b0}};
        sr_ts_q[0] <= {TS_W{1'b0}};
    end else begin
        prev_q <= hit_i;
        sr_hit_q[0] <= edges;
        sr_ts_q[0] <= ts_q;
    end
end

genvar g;
generate
    for (g = 1; g < PIPE_DEPTH; g = g + 1) begin : stage
        always @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                sr_hit_q[g] <= {NUM_CHAN{1'b0}};
                sr_ts_q[g] <= {TS_W{1'b0}};
            end else begin
                sr_hit_q[g] <= sr_hit_q[g-1];
                sr_ts_q[g] <= sr_ts_q[g-1];
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// acceptance at shift register output
// ----------------------------------------------------------------
wire [NUM_CHAN-1:0] out_hits = sr_hit_q[PIPE_DEPTH-1];
wire nonzero = |out_hits;
wire accept = (accept_mode_i == `MODE_AUTO) ? nonzero :
    (nonzero && popcount(out_hits) >= min_hits_i);
wire [`WORD_BITS-1:0] event_word = {sr_ts_q[PIPE_DEPTH-1], out_hits};

// ----------------------------------------------------------------
// event queue
// ----------------------------------------------------------------
reg [`WORD_BITS-1:0] mem_q [0:FIFO_DEPTH-1];
reg [AW-1:0] wr_q;
reg [AW-1:0] rd_q;
reg [AW:0] cnt_q;
reg ovf_q;
wire full = (cnt_q == FIFO_FULL);
wire empty = (cnt_q == {(AW+1){1'b0}});
wire push = accept && !full;
wire pop;

always @(posedge sys_clk_i) begin
    if (push) begin
        mem_q[wr_q] <= event_word;
    end
end

always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        wr_q <= {AW{1'b0}};
        rd_q <= {AW{1'b0}};
        cnt_q <= {(AW+1){1'b0}};
        ovf_q <= 1'b0;
    end else begin
        if (push) begin
            wr_q <= (wr_q == PTR_LAST) ? {AW{1'b0}} : wr_q + 1'b1;
        end
        if (pop) begin
            rd_q <= (rd_q == PTR_LAST) ? {AW{1'b0}} : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
        end
        // a drop in the clearing cycle keeps the flag set
        if (accept && full) begin
            ovf_q <= 1'b1;
        end else if (ovf_clear_i) begin
            ovf_q <= 1'b0;
        end
    end
end

assign overflow_o = ovf_q;

// ----------------------------------------------------------------
// serial transmitter
// ----------------------------------------------------------------
reg [1:0] state_q;
reg [FB-1:0] shift_q;
reg [CW-1:0] bit_q;
assign pop = (state_q == S_IDLE) && !empty;

always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        state_q <= S_IDLE;
        shift_q <= {FB{1'b0}};
        bit_q <= {CW{1'b0}};
    end else begin
        case (state_q)
            S_IDLE: begin
                if (!empty) begin
                    // header first, then the 88-bit word msb first
                    shift_q <= {`HDR_CODE, mem_q[rd_q],
                        {(FB - `FRAME_BITS){1'b0}}};
                    bit_q <= {CW{1'b0}};
                    state_q <= S_SEND;
                end
            end
            S_SEND: begin
                shift_q <= {shift_q[FB-LANES-1:0], {LANES{1'b0}}};
                bit_q <= bit_q + 1'b1;
                if (bit_q == FRAME_LAST) begin
                    state_q <= S_IDLE;
                end
            end
            default: begin
                state_q <= S_IDLE;
            end
        endcase
    end
end

assign tx_frame_o = (state_q == S_SEND);
// register is fully shifted out by the last frame cycle, so idle lanes are 0
assign tx_data_o = shift_q[FB-1:FB-LANES];

endmodule
